//--- common/cpt_params.svh
`ifndef CPT_PARAMS_SVH
`define CPT_PARAMS_SVH
// ==========================================
// Register indices
`define CPT_A_CTRL0 3'h0
`define CPT_A_CTRL1 3'h1
`define CPT_A_CNT_LO 3'h2
`define CPT_A_CNT_HI 3'h3
`define CPT_A_CMPA_LO 3'h4
`define CPT_A_CMPA_HI 3'h5
`define CPT_A_CMPP 3'h6
`define CPT_A_FLAGS 3'h7
`define CPT_RST_BYTE 8'h00
// ==========================================
// Field positions
`define CPT_C0_PAUSE 7
`define CPT_C0_CKS 6:4
`define CPT_C0_EN 3
`define CPT_C0_MASK 8'hF8
`define CPT_C1_MODE 7:6
`define CPT_C1_IOF 5:4
`define CPT_C1_OC 3
`define CPT_C1_POL 2
`define CPT_C1_DPX 1
`define CPT_C1_CCLR 0
`define CPT_F_A 0
`define CPT_F_P 1
// ==========================================
// Codes
`define CPT_MODE_CMP 2'h0
`define CPT_MODE_PWM 2'h2
`define CPT_MODE_TMR 2'h3
`define CPT_IO_NONE 2'h0
`define CPT_IO_LOW 2'h1
`define CPT_IO_HIGH 2'h2
`define CPT_IO_TOG 2'h3
`define CPT_PWM_ACT 2'h1
`define CPT_PWM_WAVE 2'h2
`define CPT_CK_SYS4 3'h0
`define CPT_CK_SYS 3'h1
`define CPT_CK_H16 3'h2
`define CPT_CK_H64 3'h3
`define CPT_CK_SUB_A 3'h4
`define CPT_CK_SUB_B 3'h5
`define CPT_CK_EXT_R 3'h6
`define CPT_CK_EXT_F 3'h7
// ==========================================
// Divide ratios and counter span
`define CPT_DIV_SYS 4
`define CPT_DIV_H16 16
`define CPT_DIV_H64 64
`define CPT_FULL_SPAN 17'h10000
`endif

//--- common/cpt_pkg.sv
`include "cpt_params.svh"
package cpt_pkg;
   typedef struct packed {
      logic [7:0] ctrl0;
      logic [7:0] ctrl1;
      logic [7:0] cmpa_lo;
      logic [7:0] cmpa_hi;
      logic [7:0] cmpp;
      logic [15:0] cnt;
      logic flag_a;
      logic flag_p;
      logic en_prev;
      logic a_evt;
      logic en_rise;
      logic [7:0] rdata;
   } cpt_core_t;

   typedef struct packed {
      logic [5:0] sys_div;
      logic [5:0] h_div;
      logic ext_prev;
      logic tick;
   } cpt_tick_t;

   typedef struct packed {
      logic cmp_lvl;
      logic pin;
      logic drive_n;
   } cpt_out_t;

   // Compare point; zero means a full 16-bit wrap
   function automatic logic [16:0] cpt_span(input logic [15:0] v);
      cpt_span = (v == 16'h0000) ? `CPT_FULL_SPAN : {1'b0, v};
   endfunction
endpackage

//--- common/cpt_cnt_if.sv
`timescale 1ns/10ps
interface cpt_cnt_if;
   logic [2:0] clk_sel;
   logic count_tick;
   logic [1:0] mode;
   logic [1:0] out_func;
   logic out_init;
   logic out_inv;
   logic en_rise;
   logic a_evt;
   logic pwm_act;
   modport tick_gen (input clk_sel, output count_tick);
   modport pin_drv (input mode, out_func, out_init, out_inv, en_rise, a_evt, pwm_act);
   modport core (output clk_sel, mode, out_func, out_init, out_inv, en_rise, a_evt,
                 pwm_act, input count_tick);
endinterface

//--- rtl/cpt_tick.sv
`timescale 1ns/10ps
`include "cpt_params.svh"
module cpt_tick (
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   input wire logic high_clk_tick_i,
   input wire logic sub_clk_tick_i,
   input wire logic ext_clk_pin_i,
   cpt_cnt_if.tick_gen cif
);
   cpt_pkg::cpt_tick_t q;
   cpt_pkg::cpt_tick_t d;
   logic h_wrap;

   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n_i);

   // ==========================================
   // Counting clock selection
   always_comb begin
      d = q;
      d.ext_prev = ext_clk_pin_i;
      d.sys_div = (q.sys_div == 6'(`CPT_DIV_SYS - 1)) ? 6'h00 : q.sys_div + 6'h01;
      h_wrap = (cif.clk_sel == `CPT_CK_H16) ? (q.h_div >= 6'(`CPT_DIV_H16 - 1))
                                             : (q.h_div == 6'(`CPT_DIV_H64 - 1));
      if (high_clk_tick_i) begin
         d.h_div = h_wrap ? 6'h00 : q.h_div + 6'h01;
      end
      unique case (cif.clk_sel)
         `CPT_CK_SYS4: d.tick = (q.sys_div == 6'h00);
         `CPT_CK_SYS: d.tick = 1'b1;
         `CPT_CK_H16, `CPT_CK_H64: d.tick = high_clk_tick_i & h_wrap;
         `CPT_CK_SUB_A, `CPT_CK_SUB_B: d.tick = sub_clk_tick_i;
         `CPT_CK_EXT_R: d.tick = ext_clk_pin_i & ~q.ext_prev;
         `CPT_CK_EXT_F: d.tick = ~ext_clk_pin_i & q.ext_prev;
      endcase
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign cif.count_tick = q.tick;

   a_sys_rate: assert property ((cif.clk_sel == `CPT_CK_SYS) |=> cif.count_tick)
      else $error("system clock select gave no tick");
endmodule

//--- rtl/cpt_out.sv
`timescale 1ns/10ps
`include "cpt_params.svh"
module cpt_out (
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   cpt_cnt_if.pin_drv cif,
   output logic pin_o,
   output logic drive_n_o
);
   cpt_pkg::cpt_out_t q;
   cpt_pkg::cpt_out_t d;
   logic pwm_lvl;

   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n_i);

   // ==========================================
   // Pin level
   always_comb begin
      d = q;
      pwm_lvl = ~cif.out_init;
      if (cif.en_rise) begin
         d.cmp_lvl = cif.out_init;
      end else if (cif.a_evt) begin
         unique case (cif.out_func)
            `CPT_IO_NONE: d.cmp_lvl = q.cmp_lvl;
            `CPT_IO_LOW: d.cmp_lvl = 1'b0;
            `CPT_IO_HIGH: d.cmp_lvl = 1'b1;
            `CPT_IO_TOG: d.cmp_lvl = ~q.cmp_lvl;
         endcase
      end
      unique case (cif.out_func)
         `CPT_PWM_ACT: pwm_lvl = cif.out_init;
         `CPT_PWM_WAVE: pwm_lvl = cif.pwm_act ? cif.out_init : ~cif.out_init;
         default: pwm_lvl = ~cif.out_init;
      endcase
      d.drive_n = 1'b0;
      unique case (cif.mode)
         `CPT_MODE_CMP: d.pin = d.cmp_lvl ^ cif.out_inv;
         `CPT_MODE_PWM: d.pin = pwm_lvl ^ cif.out_inv;
         default: begin
            d.pin = 1'b0;
            d.drive_n = 1'b1;
         end
      endcase
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign pin_o = q.pin;
   assign drive_n_o = q.drive_n;

   a_pin_free: assert property ((cif.mode == `CPT_MODE_TMR) |=> drive_n_o)
      else $error("pin driven in timer mode");
   a_init_level: assert property ((cif.en_rise && cif.mode == `CPT_MODE_CMP)
      |=> (pin_o == ($past(cif.out_init) ^ $past(cif.out_inv))))
      else $error("pin not at initial level after enable");
endmodule

//--- rtl/cpt_timer.sv
// Chosen here: the plain strobed port and the placing of the registers.
`timescale 1ns/10ps
`include "cpt_params.svh"
module cpt_timer (
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   input wire logic [2:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rdata_o,
   input wire logic high_clk_tick_i,
   input wire logic sub_clk_tick_i,
   input wire logic ext_clk_pin_i,
   output logic out_pin_o,
   output logic out_pin_drive_n_o,
   output logic match_a_flag_o,
   output logic match_p_flag_o
);
   cpt_pkg::cpt_core_t q;
   cpt_pkg::cpt_core_t d;

   logic en;
   logic pause;
   logic [1:0] mode;
   logic is_pwm;
   logic [15:0] cmpa;
   logic [16:0] inc;
   logic [16:0] a_span;
   logic [16:0] p_span;
   logic [16:0] duty;
   logic [16:0] period;
   logic a_hit;
   logic p_hit;
   logic clr_on_a;
   logic clr;
   logic a_set;
   logic p_set;
   logic run;

   cpt_cnt_if cif ();

   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n_i);

   // ==========================================
   // Decode of control fields
   assign en = q.ctrl0[`CPT_C0_EN];
   assign pause = q.ctrl0[`CPT_C0_PAUSE];
   assign mode = q.ctrl1[`CPT_C1_MODE];
   assign is_pwm = (mode == `CPT_MODE_PWM);
   assign cmpa = {q.cmpa_hi, q.cmpa_lo};

   // ==========================================
   // Comparators
   assign inc = {1'b0, q.cnt} + 17'h00001;
   assign a_span = cpt_pkg::cpt_span(cmpa);
   assign p_span = cpt_pkg::cpt_span({q.cmpp, 8'h00});
   assign a_hit = (inc == a_span);
   assign p_hit = (inc == p_span);

   // Which comparator ends the count cycle
   assign clr_on_a = is_pwm ? q.ctrl1[`CPT_C1_DPX] : q.ctrl1[`CPT_C1_CCLR];
   assign clr = clr_on_a ? a_hit : p_hit;

   // Flag generation
   assign a_set = a_hit && (is_pwm || !clr_on_a || cmpa != 16'h0000);
   assign p_set = p_hit && (is_pwm || !clr_on_a);

   // Counting event gate
   assign run = en && q.en_prev && !pause && cif.count_tick;

   // ==========================================
   // PWM compare
   assign duty = q.ctrl1[`CPT_C1_DPX] ? p_span : {1'b0, cmpa};
   assign period = q.ctrl1[`CPT_C1_DPX] ? a_span : p_span;
   assign cif.pwm_act = ({1'b0, q.cnt} < duty);

   // ==========================================
   // Next state
   always_comb begin
      d = q;
      d.a_evt = 1'b0;
      d.en_rise = 1'b0;
      d.rdata = `CPT_RST_BYTE;
      d.en_prev = en;

      // Register writes
      if (wr_i) begin
         unique case (addr_i)
            `CPT_A_CTRL0: d.ctrl0 = wdata_i & `CPT_C0_MASK;
            `CPT_A_CTRL1: d.ctrl1 = wdata_i;
            `CPT_A_CMPA_LO: d.cmpa_lo = wdata_i;
            `CPT_A_CMPA_HI: d.cmpa_hi = wdata_i;
            `CPT_A_CMPP: d.cmpp = wdata_i;
            `CPT_A_FLAGS: begin
               if (wdata_i[`CPT_F_A]) begin
                  d.flag_a = 1'b0;
               end
               if (wdata_i[`CPT_F_P]) begin
                  d.flag_p = 1'b0;
               end
            end
            `CPT_A_CNT_LO, `CPT_A_CNT_HI: ;
         endcase
      end

      // Counter
      if (en && !q.en_prev) begin
         d.cnt = 16'h0000;
         d.en_rise = 1'b1;
      end else if (run) begin
         d.cnt = clr ? 16'h0000 : inc[15:0];
         d.a_evt = a_set && (mode == `CPT_MODE_CMP);
      end

      // Flags; a set in the clearing cycle wins
      if (run && a_set) begin
         d.flag_a = 1'b1;
      end
      if (run && p_set) begin
         d.flag_p = 1'b1;
      end

      // Read data, valid in the cycle after the strobe only
      if (rd_i) begin
         unique case (addr_i)
            `CPT_A_CTRL0: d.rdata = q.ctrl0;
            `CPT_A_CTRL1: d.rdata = q.ctrl1;
            `CPT_A_CNT_LO: d.rdata = q.cnt[7:0];
            `CPT_A_CNT_HI: d.rdata = q.cnt[15:8];
            `CPT_A_CMPA_LO: d.rdata = q.cmpa_lo;
            `CPT_A_CMPA_HI: d.rdata = q.cmpa_hi;
            `CPT_A_CMPP: d.rdata = q.cmpp;
            `CPT_A_FLAGS: begin
               d.rdata[`CPT_F_A] = q.flag_a;
               d.rdata[`CPT_F_P] = q.flag_p;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   // ==========================================
   // Outputs and link to the sub-blocks
   assign rdata_o = q.rdata;
   assign match_a_flag_o = q.flag_a;
   assign match_p_flag_o = q.flag_p;
   assign cif.clk_sel = q.ctrl0[`CPT_C0_CKS];
   assign cif.mode = mode;
   assign cif.out_func = q.ctrl1[`CPT_C1_IOF];
   assign cif.out_init = q.ctrl1[`CPT_C1_OC];
   assign cif.out_inv = q.ctrl1[`CPT_C1_POL];
   assign cif.en_rise = q.en_rise;
   assign cif.a_evt = q.a_evt;

   cpt_tick u_tick (
      .clk_sys_i(clk_sys_i),
      .rst_n_i(rst_n_i),
      .high_clk_tick_i(high_clk_tick_i),
      .sub_clk_tick_i(sub_clk_tick_i),
      .ext_clk_pin_i(ext_clk_pin_i),
      .cif(cif)
   );

   cpt_out u_out (
      .clk_sys_i(clk_sys_i),
      .rst_n_i(rst_n_i),
      .cif(cif),
      .pin_o(out_pin_o),
      .drive_n_o(out_pin_drive_n_o)
   );

   // ==========================================
   // Checks
   a_en_rise_zero: assert property ((en && !q.en_prev) |=> (q.cnt == 16'h0000))
      else $error("counter not zeroed on enable rise");

   a_off_hold: assert property (!en |=> (q.cnt == $past(q.cnt)))
      else $error("counter moved while disabled");

   a_count_step: assert property ((run && !clr)
      |=> (q.cnt == $past(q.cnt) + 16'h0001))
      else $error("counter did not step by one");

   a_pause_hold: assert property ((en && q.en_prev && pause)
      |=> (q.cnt == $past(q.cnt)))
      else $error("counter moved while paused");

   a_clear_wrap: assert property ((run && clr) |=> (q.cnt == 16'h0000))
      else $error("counter not cleared on match");

   a_p_period: assert property ((run && p_set && q.cmpp != 8'h00)
      |-> (q.cnt == {q.cmpp - 8'h01, 8'hFF}))
      else $error("P match at wrong count");

   a_no_p_flag: assert property ((run && !is_pwm && q.ctrl1[`CPT_C1_CCLR])
      |=> !$rose(q.flag_p))
      else $error("P flag set with clear on A");

   a_a_zero_quiet: assert property ((!is_pwm && q.ctrl1[`CPT_C1_CCLR]
      && cmpa == 16'h0000) |-> !a_set)
      else $error("A flag with zero A in clear on A");

   a_flag_wins: assert property ((run && a_set) |=> q.flag_a)
      else $error("A flag lost on match");

   a_pin_evt: assert property (q.a_evt
      |-> ($past(mode) == `CPT_MODE_CMP && $past(a_set)))
      else $error("pin event without A match");

   a_pwm_full: assert property ((is_pwm && duty >= period
      && {1'b0, q.cnt} < period) |-> cif.pwm_act)
      else $error("PWM not fully on");

   a_read_cnt: assert property ((rd_i && addr_i == `CPT_A_CNT_HI)
      |=> (rdata_o == $past(q.cnt[15:8])))
      else $error("counter high byte read wrong");

   a_read_idle: assert property (!rd_i |=> (rdata_o == 8'h00))
      else $error("read data outside read cycle");

   a_cmpa_write: assert property ((wr_i && addr_i == `CPT_A_CMPA_LO)
      |=> (q.cmpa_lo == $past(wdata_i)))
      else $error("compare A low byte not written");

   a_cmpa_hi_write: assert property ((wr_i && addr_i == `CPT_A_CMPA_HI)
      |=> (q.cmpa_hi == $past(wdata_i)))
      else $error("compare A high byte not written");

   a_cmpp_write: assert property ((wr_i && addr_i == `CPT_A_CMPP)
      |=> (q.cmpp == $past(wdata_i)))
      else $error("compare P not written");

   a_mode_write: assert property ((wr_i && addr_i == `CPT_A_CTRL1)
      |=> (mode == $past(wdata_i[7:6])))
      else $error("mode field not written");

   a_read_cnt_lo: assert property ((rd_i && addr_i == `CPT_A_CNT_LO)
      |=> (rdata_o == $past(q.cnt[7:0])))
      else $error("counter low byte read wrong");

   a_read_flags: assert property ((rd_i && addr_i == `CPT_A_FLAGS)
      |=> (rdata_o == {6'h00, $past(q.flag_p), $past(q.flag_a)}))
      else $error("flag register read wrong");

   a_cnt_read_only: assert property ((wr_i && (addr_i == `CPT_A_CNT_LO
      || addr_i == `CPT_A_CNT_HI) && !run && !(en && !q.en_prev))
      |=> (q.cnt == $past(q.cnt)))
      else $error("counter changed by a write");

   // ==========================================
   // Clearing checks
   a_p_clear_cmp: assert property ((run && !is_pwm && !q.ctrl1[`CPT_C1_CCLR] && p_hit)
      |=> (q.cnt == 16'h0000))
      else $error("counter not cleared on P match");

   a_a_clear_cmp: assert property ((run && !is_pwm && q.ctrl1[`CPT_C1_CCLR] && a_hit)
      |=> (q.cnt == 16'h0000))
      else $error("counter not cleared on A match");

   a_pwm_p_period: assert property ((run && is_pwm && !q.ctrl1[`CPT_C1_DPX] && p_hit)
      |=> (q.cnt == 16'h0000))
      else $error("PWM period not set by P");

   a_pwm_a_period: assert property ((run && is_pwm && q.ctrl1[`CPT_C1_DPX] && a_hit)
      |=> (q.cnt == 16'h0000))
      else $error("PWM period not set by A");

   a_pwm_no_cclr: assert property ((run && is_pwm && !q.ctrl1[`CPT_C1_DPX] && a_hit
      && !p_hit && cmpa != 16'h0000) |=> (q.cnt != 16'h0000))
      else $error("PWM counter cleared by A with P period");

   // ==========================================
   // Flag checks
   a_p_flag_set: assert property ((run && p_set) |=> q.flag_p)
      else $error("P flag lost on match");

   a_pwm_a_flag: assert property ((run && is_pwm && a_hit) |=> q.flag_a)
      else $error("A flag missing in PWM mode");

   a_pwm_p_flag: assert property ((run && is_pwm && p_hit) |=> q.flag_p)
      else $error("P flag missing in PWM mode");

   // ==========================================
   // Pin checks
   a_pwm_force: assert property ((is_pwm && q.ctrl1[`CPT_C1_IOF] == `CPT_IO_NONE)
      |=> (out_pin_o == $past(~q.ctrl1[`CPT_C1_OC] ^ q.ctrl1[`CPT_C1_POL])))
      else $error("PWM pin not at forced inactive level");

   a_pwm_wave: assert property ((is_pwm && q.ctrl1[`CPT_C1_IOF] == `CPT_PWM_WAVE)
      |=> (out_pin_o == $past((cif.pwm_act ~^ q.ctrl1[`CPT_C1_OC])
      ^ q.ctrl1[`CPT_C1_POL])))
      else $error("PWM waveform level wrong");

   a_cmp_pin_hold: assert property ((mode == `CPT_MODE_CMP && !q.a_evt && !q.en_rise
      && $stable(q.ctrl1)) |=> $stable(out_pin_o))
      else $error("compare pin changed without A match");
endmodule

//--- test/test_cpt_timer.sv
`timescale 1ns/10ps
`include "cpt_params.svh"
module test_cpt_timer;
   logic clk_sys_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic [2:0] addr_i = 3'h0;
   logic [7:0] wdata_i = 8'h00;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic high_clk_tick_i = 1'b0;
   logic sub_clk_tick_i = 1'b0;
   logic ext_clk_pin_i = 1'b0;
   logic [7:0] rdata_o;
   logic out_pin_o;
   logic out_pin_drive_n_o;
   logic match_a_flag_o;
   logic match_p_flag_o;
   logic rd_d = 1'b0;
   logic [15:0] lfsr = 16'h5763;
   logic [7:0] exp_q[$];
   string name_q[$];
   int bad_count = 0;
   int tests_run = 0;

   cpt_timer i_cpt_timer (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
      .high_clk_tick_i(high_clk_tick_i), .sub_clk_tick_i(sub_clk_tick_i),
      .ext_clk_pin_i(ext_clk_pin_i), .out_pin_o(out_pin_o),
      .out_pin_drive_n_o(out_pin_drive_n_o), .match_a_flag_o(match_a_flag_o),
      .match_p_flag_o(match_p_flag_o));

   // ==========================================
   // Clock, random source, read monitor
   always #25 clk_sys_i = ~clk_sys_i;

   function automatic logic [15:0] lfsr_next(input logic [15:0] s);
      lfsr_next = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   always @(posedge clk_sys_i) begin
      lfsr <= lfsr_next(lfsr);
      high_clk_tick_i <= lfsr[3];
      rd_d <= rd_i;
   end

   task check(input string n, input logic [15:0] s, input logic [15:0] e);
      tests_run++;
      if (s !== e) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask

   always @(negedge clk_sys_i) begin
      if (rd_d && exp_q.size() > 0) begin
         check(name_q.pop_front(), {8'h00, rdata_o}, {8'h00, exp_q.pop_front()});
      end
   end

   task final_report;
      if (bad_count == 0 && tests_run > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   initial begin
      repeat (90000) @(posedge clk_sys_i);
      bad_count++;
      final_report;
   end

   // ==========================================
   // Bus and stimulus tasks
   task wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk_sys_i);
      wr_i <= 1'b1;
      addr_i <= a;
      wdata_i <= d;
      @(posedge clk_sys_i);
      wr_i <= 1'b0;
   endtask

   task rd(input logic [2:0] a, input logic [7:0] e, input string n);
      @(posedge clk_sys_i);
      rd_i <= 1'b1;
      addr_i <= a;
      exp_q.push_back(e);
      name_q.push_back(n);
      @(posedge clk_sys_i);
      rd_i <= 1'b0;
   endtask

   task cyc(input int n);
      repeat (n) @(posedge clk_sys_i);
      #5;
   endtask

   task pulse;
      @(posedge clk_sys_i);
      sub_clk_tick_i <= 1'b1;
      ext_clk_pin_i <= 1'b1;
      @(posedge clk_sys_i);
      sub_clk_tick_i <= 1'b0;
      ext_clk_pin_i <= 1'b0;
      cyc(3);
   endtask

   task flags(input logic [1:0] f);
      check("flag a", match_a_flag_o, f[0]);
      check("flag p", match_p_flag_o, f[1]);
      rd(`CPT_A_FLAGS, {6'h00, f}, "flag register");
   endtask

   task setup(input logic [7:0] c1, input logic [15:0] a, input logic [7:0] p,
              input logic [7:0] c0);
      wr(`CPT_A_CTRL0, 8'h00);
      wr(`CPT_A_CTRL1, c1);
      wr(`CPT_A_CMPA_LO, a[7:0]);
      wr(`CPT_A_CMPA_HI, a[15:8]);
      wr(`CPT_A_CMPP, p);
      wr(`CPT_A_FLAGS, 8'h03);
      wr(`CPT_A_CTRL0, c0);
      cyc(8);
   endtask

   // ==========================================
   // Main sequence
   initial begin
      logic [15:0] v;
      int hi;
      logic [2:0] ck [4] = '{`CPT_CK_SUB_A, `CPT_CK_SUB_B, `CPT_CK_EXT_R, `CPT_CK_EXT_F};
      logic [7:0] ct1 [4] = '{8'h01, 8'h19, 8'h21, 8'h25};
      logic [3:0] after = 4'b0100;
      logic [7:0] pc1 [7] = '{8'hA8, 8'hA9, 8'hAC, 8'hA8, 8'hAA, 8'h88, 8'h98};
      logic [15:0] pa [7] = '{16'h0080, 16'h0080, 16'h0040, 16'h0200, 16'h0400, 16'h0080,
                              16'h0080};
      int pn [7] = '{256, 256, 256, 256, 1024, 256, 256};
      int ph [7] = '{128, 128, 192, 256, 256, 0, 256};
      logic [1:0] pf [7] = '{2'b11, 2'b11, 2'b11, 2'b10, 2'b11, 2'b11, 2'b11};
      repeat (6) @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
      for (int i = 2; i < 8; i++) begin
         rd(3'(i), 8'h00, "reset value");
      end
      wr(`CPT_A_CTRL0, 8'hFF);
      rd(`CPT_A_CTRL0, 8'hF8, "ctrl0 readback");
      wr(`CPT_A_CNT_LO, 8'hFF);
      wr(`CPT_A_CNT_HI, 8'hFF);
      rd(`CPT_A_CNT_LO, 8'h00, "counter low");
      rd(`CPT_A_CNT_HI, 8'h00, "counter high");
      repeat (4) begin
         v = lfsr;
         wr(`CPT_A_CMPA_LO, v[7:0]);
         wr(`CPT_A_CMPA_HI, v[15:8]);
         wr(`CPT_A_CMPP, v[11:4]);
         rd(`CPT_A_CMPA_LO, v[7:0], "compare a low");
         rd(`CPT_A_CMPA_HI, v[15:8], "compare a high");
         rd(`CPT_A_CMPP, v[11:4], "compare p");
      end
      for (int k = 0; k < 4; k++) begin
         setup(8'h00, 16'h0000, 8'h00, {1'b0, ck[k], 4'h8});
         rd(`CPT_A_CNT_LO, 8'h00, "count after enable");
         repeat (5) pulse();
         rd(`CPT_A_CNT_LO, 8'h05, "count per event");
         wr(`CPT_A_CTRL0, {1'b0, ck[k], 4'h0});
         repeat (3) pulse();
         rd(`CPT_A_CNT_LO, 8'h05, "count held");
      end
      for (int k = 0; k < 4; k++) begin
         setup(ct1[k], 16'h0180, 8'h01, 8'h18);
         check("pin initial", out_pin_o, ct1[k][3] ^ ct1[k][2]);
         cyc(420);
         check("pin after match", out_pin_o, after[k]);
         check("pin driven", out_pin_drive_n_o, 1'b0);
         flags(2'b01);
      end
      setup(8'h21, 16'h0000, 8'h01, 8'h18);
      cyc(65600);
      flags(2'b00);
      check("pin no match", out_pin_o, 1'b0);
      setup(8'h00, 16'h0005, 8'h01, 8'h18);
      cyc(600);
      rd(`CPT_A_CNT_HI, 8'h00, "p period");
      flags(2'b11);
      setup(8'hC0, 16'h0005, 8'h01, 8'h18);
      cyc(600);
      check("pin released", out_pin_drive_n_o, 1'b1);
      flags(2'b11);
      setup(8'h00, 16'h0005, 8'h00, 8'h18);
      cyc(400);
      rd(`CPT_A_CNT_HI, 8'h01, "full span");
      for (int k = 0; k < 7; k++) begin
         hi = 0;
         setup(pc1[k], pa[k], 8'h01, 8'h18);
         cyc(20);
         repeat (pn[k]) begin
            @(negedge clk_sys_i);
            hi += (out_pin_o === 1'b1);
         end
         check("pwm active cycles", hi, ph[k]);
         flags(pf[k]);
      end
      cyc(4);
      final_report;
   end
endmodule
